/* File: logic/smr_pkg.sv */
// package: register indices, field positions and reset values of the supply monitor registers
package smr_pkg;
    // register indices within the module
    localparam logic [4:0] IDX_THRESH = 5'h00;
    localparam logic [4:0] IDX_PWR_EN = 5'h01;
    localparam logic [4:0] IDX_IRQ_EN = 5'h0A;
    localparam logic [4:0] IDX_STATUS = 5'h0B;
    // reset values
    localparam logic [15:0] PWR_EN_RST = 16'h0400;
    localparam logic [15:0] THRESH_RST = 16'h0000;
    localparam logic [15:0] IRQ_EN_RST = 16'h0001;
    // writable bit masks
    localparam logic [15:0] PWR_EN_WMASK = 16'h1CFB;
    localparam logic [15:0] IRQ_EN_WMASK = 16'h0077;
    localparam logic [15:0] THRESH_WMASK = 16'h003F;
    // field positions
    localparam int PE_IO_DET = 12;
    localparam int PE_CORE_DET = 11;
    localparam int PE_CORE_RST = 10;
    localparam int IE_IO = 5;
    localparam int IE_CORE = 4;
    localparam int ST_IO_LVL = 15;
    localparam int ST_CORE_LVL = 14;
    localparam int ST_IO_FLAG = 5;
    localparam int ST_CORE_FLAG = 4;
    localparam int ST_OVR = 2;
endpackage

/* File: logic/smr_regs.sv */
// supply monitor register bank: power enable, interrupt enable, status, threshold select
//
// Functional notes
// - power enable resets to 0400h always
// - power enable bits 15,14,13,9,8,2 read zero
// - bit 12 enables io brownout detection
// - bit 11 enables core brownout detection
// - bit 10 enables core brownout reset
// - cpu needs global enable and mask five
// - irq enable bits 15..7,3 read zero
// - irq enable bit 5 gates io flag
// - irq enable bit 4 gates core flag
// - irq enable bit 0 spare, resets one
// - overrun clears any reset; others only power-on
// - status read clears latched flags only
// - status bit 15 live io level
// - status bit 14 live core level
// - status bit 5 latches io brownout
// - status bit 4 latches core brownout
// - status read-only, reserved bits zero
// - threshold selectors; reset selector power-on only
// - hold reset low during core brownout
`timescale 1ns/1ps
module smr_regs
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [4:0] reg_idx,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic io_cmp_above,
    input wire logic core_cmp_above,
    input wire logic core_rst_cmp_below,
    input wire logic converter_overrun_set,
    input wire logic global_irq_enable,
    input wire logic irq_mask_bit_five,
    output logic io_brownout_irq,
    output logic core_brownout_irq,
    output logic cpu_irq_req,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic [1:0] io_irq_threshold_sel,
    output logic [1:0] core_irq_threshold_sel,
    output logic [1:0] core_reset_threshold_sel,
    output logic io_brownout_detect_en,
    output logic core_brownout_detect_en,
    output logic core_brownout_reset_en
);
    logic [15:0] pwr_en_r;
    logic [15:0] irq_en_r;
    logic [3:0] irq_thresh_r;
    logic [1:0] rst_thresh_r;
    logic [5:0] thresh_r;
    logic [1:0] io_sync_r;
    logic [1:0] core_sync_r;
    logic [1:0] rst_sync_r;
    logic io_flag_r;
    logic core_flag_r;
    logic ovr_flag_r;
    logic io_lvl_r;
    logic core_lvl_r;
    logic wr_pe;
    logic wr_ie;
    logic wr_th;
    logic rd_st;
    logic io_det;
    logic core_det;
    logic [15:0] rdata_nxt;

    // write and read strobes
    assign wr_pe = reg_sel && reg_wr && (reg_idx == smr_pkg::IDX_PWR_EN);
    assign wr_ie = reg_sel && reg_wr && (reg_idx == smr_pkg::IDX_IRQ_EN);
    assign wr_th = reg_sel && reg_wr && (reg_idx == smr_pkg::IDX_THRESH);
    assign rd_st = reg_sel && reg_rd && (reg_idx == smr_pkg::IDX_STATUS);

    // --------------------------------------------------
    // comparator synchronisers
    // --------------------------------------------------
    // two-stage sync
    always_ff @(posedge ref_clk)
    begin
        io_sync_r <= {io_sync_r[0], io_cmp_above};
        core_sync_r <= {core_sync_r[0], core_cmp_above};
        rst_sync_r <= {rst_sync_r[0], core_rst_cmp_below};
    end

    assign io_det = pwr_en_r[smr_pkg::PE_IO_DET] && !io_sync_r[1];
    assign core_det = pwr_en_r[smr_pkg::PE_CORE_DET] && !core_sync_r[1];

    // --------------------------------------------------
    // control registers
    // --------------------------------------------------
    // power enable, masked writes
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            pwr_en_r <= smr_pkg::PWR_EN_RST;
        else if (wr_pe)
            pwr_en_r <= reg_wdata & smr_pkg::PWR_EN_WMASK;
    end

    // irq enable masked writes, spare bit resets one
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            irq_en_r <= smr_pkg::IRQ_EN_RST;
        else if (wr_ie)
            irq_en_r <= reg_wdata & smr_pkg::IRQ_EN_WMASK;
    end

    // interrupt selectors clear on any reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            irq_thresh_r <= smr_pkg::THRESH_RST[5:2];
        else if (wr_th)
            irq_thresh_r <= reg_wdata[5:2];
    end

    // reset selector clears only on power-on
    always_ff @(posedge ref_clk)
    begin
        if (!por_n)
            rst_thresh_r <= smr_pkg::THRESH_RST[1:0];
        else if (wr_th)
            rst_thresh_r <= reg_wdata[1:0];
    end

    // threshold image, interrupt bits 5:2 and reset bits 1:0 each owned by its own reset domain
    assign thresh_r = {irq_thresh_r, rst_thresh_r};

    // --------------------------------------------------
    // status flags
    // --------------------------------------------------
    // latch, clear on read, set wins
    always_ff @(posedge ref_clk)
    begin
        if (!por_n)
        begin
            io_flag_r <= 1'b0;
            core_flag_r <= 1'b0;
        end
        else
        begin
            io_flag_r <= io_det || (io_flag_r && !rd_st);
            core_flag_r <= core_det || (core_flag_r && !rd_st);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ovr_flag_r <= 1'b0;
        else
            ovr_flag_r <= converter_overrun_set || (ovr_flag_r && !rd_st);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!por_n)
        begin
            io_lvl_r <= 1'b0;
            core_lvl_r <= 1'b0;
        end
        else
        begin
            io_lvl_r <= pwr_en_r[smr_pkg::PE_IO_DET] && io_sync_r[1];
            core_lvl_r <= pwr_en_r[smr_pkg::PE_CORE_DET] && core_sync_r[1];
        end
    end

    // --------------------------------------------------
    // read data
    // --------------------------------------------------
    // status image, reserved bits zero
    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (reg_sel && reg_rd)
        begin
            unique case (reg_idx)
                smr_pkg::IDX_THRESH: rdata_nxt = {10'h000, thresh_r};
                smr_pkg::IDX_PWR_EN: rdata_nxt = pwr_en_r;
                smr_pkg::IDX_IRQ_EN: rdata_nxt = irq_en_r;
                smr_pkg::IDX_STATUS:
                begin
                    rdata_nxt[smr_pkg::ST_IO_LVL] = io_lvl_r;
                    rdata_nxt[smr_pkg::ST_CORE_LVL] = core_lvl_r;
                    rdata_nxt[smr_pkg::ST_IO_FLAG] = io_flag_r;
                    rdata_nxt[smr_pkg::ST_CORE_FLAG] = core_flag_r;
                    rdata_nxt[smr_pkg::ST_OVR] = ovr_flag_r;
                end
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= rdata_nxt;
    end

    // --------------------------------------------------
    // interrupt requests and reset pin
    // --------------------------------------------------
    // enable gating, cpu acceptance
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            io_brownout_irq <= 1'b0;
            core_brownout_irq <= 1'b0;
            cpu_irq_req <= 1'b0;
        end
        else
        begin
            io_brownout_irq <= io_flag_r && irq_en_r[smr_pkg::IE_IO];
            core_brownout_irq <= core_flag_r && irq_en_r[smr_pkg::IE_CORE];
            cpu_irq_req <= global_irq_enable && irq_mask_bit_five
                && ((io_flag_r && irq_en_r[smr_pkg::IE_IO])
                || (core_flag_r && irq_en_r[smr_pkg::IE_CORE]));
        end
    end

    // drive reset low during core brownout
    always_ff @(posedge ref_clk)
    begin
        reset_pin_out <= 1'b0;
        if (!por_n)
            reset_pin_oe <= 1'b0;
        else
            reset_pin_oe <= pwr_en_r[smr_pkg::PE_CORE_RST] && rst_sync_r[1];
    end

    // configuration outputs
    always_ff @(posedge ref_clk)
    begin
        io_irq_threshold_sel <= thresh_r[5:4];
        core_irq_threshold_sel <= thresh_r[3:2];
        core_reset_threshold_sel <= thresh_r[1:0];
        io_brownout_detect_en <= pwr_en_r[smr_pkg::PE_IO_DET];
        core_brownout_detect_en <= pwr_en_r[smr_pkg::PE_CORE_DET];
        core_brownout_reset_en <= pwr_en_r[smr_pkg::PE_CORE_RST];
    end

    // --------------------------------------------------
    // assertions
    // --------------------------------------------------
    sequence s_io_low;
        pwr_en_r[smr_pkg::PE_IO_DET] && !io_sync_r[1];
    endsequence

    AST_RESET_PE: assert property (@(posedge ref_clk) !rst_n |=> pwr_en_r == 16'h0400)
        else $error("power enable not 0400h after reset");
    AST_PE_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pwr_en_r & 16'hE304) == 16'h0000)
        else $error("power enable reserved bit set");
    AST_IE_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (irq_en_r & 16'hFF88) == 16'h0000)
        else $error("irq enable reserved bit set");
    AST_IO_SET: assert property (@(posedge ref_clk) disable iff (!por_n) s_io_low |=> io_flag_r)
        else $error("io flag not set on detection");
    AST_READ_CLR: assert property (@(posedge ref_clk) disable iff (!por_n)
        rd_st && !core_det |=> !core_flag_r)
        else $error("core flag not cleared by read");
    AST_IO_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !irq_en_r[smr_pkg::IE_IO] ##1 !irq_en_r[smr_pkg::IE_IO] |-> !io_brownout_irq)
        else $error("io irq while disabled");
    AST_CORE_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        core_flag_r && irq_en_r[smr_pkg::IE_CORE] |=> core_brownout_irq)
        else $error("core irq missing");
    AST_LVL_OFF: assert property (@(posedge ref_clk) disable iff (!por_n)
        !pwr_en_r[smr_pkg::PE_CORE_DET] |=> !core_lvl_r)
        else $error("core level not zero while disabled");
    AST_BOR_PIN: assert property (@(posedge ref_clk) disable iff (!por_n)
        pwr_en_r[smr_pkg::PE_CORE_RST] && rst_sync_r[1] |=> reset_pin_oe && !reset_pin_out)
        else $error("reset pin not driven low");
endmodule

/* File: test/smr_cpu_model.sv */
// cpu core model: module/index register writes and reads
`timescale 1ns/1ps
module smr_cpu_model
(
    input wire logic ref_clk,
    output logic reg_sel,
    output logic reg_wr,
    output logic reg_rd,
    output logic [4:0] reg_idx,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    // bus idle at time zero
    initial
    begin
        reg_sel = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_idx = 5'h1F;
        reg_wdata = 16'hA5A5;
    end

    // one write, held over the taking edge; released lines show inverted values
    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        @(posedge ref_clk);
        reg_sel <= 1'b1;
        reg_wr <= 1'b1;
        reg_idx <= idx;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_sel <= 1'b0;
        reg_wr <= 1'b0;
        reg_idx <= ~idx;
        reg_wdata <= ~d;
    endtask

    // one read; data is registered on the taking edge and taken at the next edge
    task automatic rd(input logic [4:0] idx, output logic [15:0] q);
        @(posedge ref_clk);
        reg_sel <= 1'b1;
        reg_rd <= 1'b1;
        reg_idx <= idx;
        @(posedge ref_clk);
        reg_sel <= 1'b0;
        reg_rd <= 1'b0;
        reg_idx <= ~idx;
        @(posedge ref_clk);
        q = reg_rdata;
    endtask
endmodule

/* File: test/smr_regs_test.sv */
// self-checking testbench for the supply monitor register bank
`timescale 1ns/1ps
module smr_regs_test;
    logic ref_clk, rst_n, por_n, reg_sel, reg_wr, reg_rd, io_cmp_above, core_cmp_above;
    logic core_rst_cmp_below, converter_overrun_set, global_irq_enable, irq_mask_bit_five;
    logic io_brownout_irq, core_brownout_irq, cpu_irq_req, reset_pin_out, reset_pin_oe;
    logic io_brownout_detect_en, core_brownout_detect_en, core_brownout_reset_en;
    logic [1:0] io_irq_threshold_sel, core_irq_threshold_sel, core_reset_threshold_sel;
    logic [4:0] reg_idx;
    logic [15:0] reg_wdata, reg_rdata, pe, ie, th, d;
    logic [3:0] cv;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;

    smr_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n), .reg_sel(reg_sel),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .io_cmp_above(io_cmp_above), .core_cmp_above(core_cmp_above),
        .core_rst_cmp_below(core_rst_cmp_below), .converter_overrun_set(converter_overrun_set),
        .global_irq_enable(global_irq_enable), .irq_mask_bit_five(irq_mask_bit_five),
        .io_brownout_irq(io_brownout_irq), .core_brownout_irq(core_brownout_irq),
        .cpu_irq_req(cpu_irq_req), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .io_irq_threshold_sel(io_irq_threshold_sel), .core_irq_threshold_sel(core_irq_threshold_sel),
        .core_reset_threshold_sel(core_reset_threshold_sel),
        .io_brownout_detect_en(io_brownout_detect_en),
        .core_brownout_detect_en(core_brownout_detect_en),
        .core_brownout_reset_en(core_brownout_reset_en));
    smr_cpu_model cpu (.ref_clk(ref_clk), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // clock and hang limit
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic rc(input string n, input logic [4:0] i, input logic [15:0] e);
        logic [15:0] q;
        cpu.rd(i, q);
        chk(n, q, e);
    endtask

    // reset held five cycles; por asserted with it when asked
    task automatic do_reset(input logic por);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        por_n <= ~por;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
    endtask

    // dip one comparator for three cycles, then let it settle
    task automatic dip(input logic core);
        @(posedge ref_clk);
        io_cmp_above <= core;
        core_cmp_above <= ~core;
        repeat (3) @(posedge ref_clk);
        io_cmp_above <= 1'b1;
        core_cmp_above <= 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {ref_clk, rst_n, por_n, converter_overrun_set, core_rst_cmp_below} = 5'h00;
        {io_cmp_above, core_cmp_above, global_irq_enable, irq_mask_bit_five} = 4'hF;
        void'($urandom(32'h271D6472));
        do_reset(1'b1);
        rc("pwr_en", 5'h01, 16'h0400);
        rc("irq_en", 5'h0A, 16'h0001);
        rc("thresh", 5'h00, 16'h0000);
        rc("status", 5'h0B, 16'h0000);
        rc("unmapped", 5'h07, 16'h0000);
        for (int k = 0; k < 8; k++)
        begin
            d = 16'($urandom);
            pe = d & 16'h1CFB;
            ie = ~d & 16'h0077;
            th = {d[7:0], d[15:8]} & 16'h003F;
            cpu.wr(5'h01, d);
            cpu.wr(5'h0A, ~d);
            cpu.wr(5'h00, {d[7:0], d[15:8]});
            cpu.wr(5'h0B, d);
            rc("pwr_en", 5'h01, pe);
            rc("irq_en", 5'h0A, ie);
            rc("thresh", 5'h00, th);
            rc("status", 5'h0B, {pe[12], pe[11], 14'h0000});
            chk("cfg", 16'({io_irq_threshold_sel, core_irq_threshold_sel,
                core_reset_threshold_sel, io_brownout_detect_en, core_brownout_detect_en,
                core_brownout_reset_en}), 16'({th[5:0], pe[12:10]}));
        end
        for (int c = 0; c < 16; c++)
        begin
            cv = 4'(c);
            cpu.wr(5'h01, 16'h1C00);
            cpu.wr(5'h0A, cv[1] ? 16'h0031 : 16'h0001);
            global_irq_enable <= cv[2];
            irq_mask_bit_five <= cv[3];
            dip(cv[0]);
            chk("irqs", 16'({io_brownout_irq, core_brownout_irq, cpu_irq_req}),
                16'({cv[1] & ~cv[0], cv[1] & cv[0], &cv[3:1]}));
            rc("status", 5'h0B, cv[0] ? 16'hC010 : 16'hC020);
            rc("status", 5'h0B, 16'hC000);
            repeat (3) @(posedge ref_clk);
            chk("irqs", 16'({io_brownout_irq, core_brownout_irq, cpu_irq_req}), 16'h0000);
        end
        @(posedge ref_clk);
        io_cmp_above <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rc("status", 5'h0B, 16'h4020);
        rc("status", 5'h0B, 16'h4020);
        dip(1'b0);
        rc("status", 5'h0B, 16'hC020);
        core_rst_cmp_below <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("rst_pin", 16'({reset_pin_oe, reset_pin_out}), 16'h0002);
        cpu.wr(5'h01, 16'h1800);
        repeat (6) @(posedge ref_clk);
        chk("rst_pin", 16'({reset_pin_oe, reset_pin_out}), 16'h0000);
        core_rst_cmp_below <= 1'b0;
        cpu.wr(5'h00, 16'h003F);
        converter_overrun_set <= 1'b1;
        @(posedge ref_clk);
        converter_overrun_set <= 1'b0;
        rc("status", 5'h0B, 16'hC004);
        dip(1'b0);
        converter_overrun_set <= 1'b1;
        @(posedge ref_clk);
        converter_overrun_set <= 1'b0;
        do_reset(1'b0);
        rc("status", 5'h0B, 16'h0020);
        rc("thresh", 5'h00, 16'h0003);
        rc("pwr_en", 5'h01, 16'h0400);
        do_reset(1'b1);
        rc("thresh", 5'h00, 16'h0000);
        print_verdict();
    end
endmodule
